/* File: hw/charger_irq_map.vh */
// Register map, field positions and detail codes for the charger status block
`ifndef CHARGER_IRQ_MAP_VH
`define CHARGER_IRQ_MAP_VH

// Register addresses
`define ADDR_IRQ_FLAGS 8'hB0
`define ADDR_IRQ_MASK 8'hB1
`define ADDR_SUMMARY_STATUS 8'hB2
`define ADDR_INPUT_BATTERY_DETAIL 8'hB3

// Reset values
`define RESET_IRQ_FLAGS 8'h00
`define RESET_IRQ_MASK 8'hFF
`define RESET_SUMMARY_STATUS 8'h00
`define RESET_INPUT_BATTERY_DETAIL 8'h00
`define READ_UNMAPPED 8'h00

// Shared bit positions of flags, mask and summary status
`define BIT_BYPASS 0
`define BIT_RESERVED 1
`define BIT_PRESENCE 2
`define BIT_CELL 3
`define BIT_CHARGE_ENGINE 4
`define BIT_WIRELESS_IN 5
`define BIT_WIRED_IN 6
`define BIT_ADAPTIVE_LIMIT 7

// Bits of the summary registers that can ever change
`define SOURCE_BITS 8'hFD

// Detection detail register layout
`define DETAIL_ABSENT_BIT 0
`define DETAIL_WIRELESS_LSB 3
`define DETAIL_WIRELESS_MSB 4
`define DETAIL_WIRED_LSB 5
`define DETAIL_WIRED_MSB 6

// Detail code widths
`define BYPASS_CODE_W 4
`define CELL_CODE_W 3
`define ENGINE_CODE_W 4
`define INPUT_CODE_W 2

// Detail code values
`define BYPASS_CODE_OK 4'h0
`define CELL_CODE_OK_HIGH 3'h3
`define CELL_CODE_OK_LOW 3'h4
`define ENGINE_CODE_PREQUAL 4'h0
`define ENGINE_CODE_FAST_CC 4'h1
`define ENGINE_CODE_FAST_CV 4'h2
`define ENGINE_CODE_TOP_OFF 4'h3
`define ENGINE_CODE_DONE 4'h5
`define ENGINE_CODE_OFF 4'h8
`define INPUT_BELOW_UVLO 2'h0
`define INPUT_LOW_HEADROOM 2'h1
`define INPUT_ABOVE_OVLO 2'h2
`define INPUT_VALID 2'h3

`endif

/* File: hw/charger_status_decode.v */
// Combinational decode of sub-block detail codes into summary and detail bytes
`timescale 1ns/1ps
`include "charger_irq_map.vh"

module charger_status_decode (
   input wire [`BYPASS_CODE_W-1:0] bypassDetailCode,
   input wire [`CELL_CODE_W-1:0] cellDetailCode,
   input wire [`ENGINE_CODE_W-1:0] chargeEngineDetailCode,
   input wire thermalRegulationActive,
   input wire [`INPUT_CODE_W-1:0] wirelessInDetailCode,
   input wire [`INPUT_CODE_W-1:0] wiredInDetailCode,
   input wire cellAbsentFlag,
   input wire adaptiveInputCurrentLimit,
   output reg [7:0] summary,
   output reg [7:0] detail
);

   reg engineCodeGood;

   always @* begin
      engineCodeGood = (chargeEngineDetailCode == `ENGINE_CODE_PREQUAL) ||
                       (chargeEngineDetailCode == `ENGINE_CODE_FAST_CC) ||
                       (chargeEngineDetailCode == `ENGINE_CODE_FAST_CV) ||
                       (chargeEngineDetailCode == `ENGINE_CODE_TOP_OFF) ||
                       (chargeEngineDetailCode == `ENGINE_CODE_DONE) ||
                       (chargeEngineDetailCode == `ENGINE_CODE_OFF);
      summary = `RESET_SUMMARY_STATUS;
      summary[`BIT_BYPASS] = (bypassDetailCode == `BYPASS_CODE_OK);
      summary[`BIT_PRESENCE] = ~cellAbsentFlag;
      summary[`BIT_CELL] = (cellDetailCode == `CELL_CODE_OK_HIGH) ||
                           (cellDetailCode == `CELL_CODE_OK_LOW);
      // Thermal fold-back overrides an otherwise good engine code
      summary[`BIT_CHARGE_ENGINE] = engineCodeGood & ~thermalRegulationActive;
      summary[`BIT_WIRELESS_IN] = (wirelessInDetailCode == `INPUT_VALID);
      summary[`BIT_WIRED_IN] = (wiredInDetailCode == `INPUT_VALID);
      summary[`BIT_ADAPTIVE_LIMIT] = ~adaptiveInputCurrentLimit;
      detail = `RESET_INPUT_BATTERY_DETAIL;
      detail[`DETAIL_ABSENT_BIT] = cellAbsentFlag;
      detail[`DETAIL_WIRELESS_MSB:`DETAIL_WIRELESS_LSB] = wirelessInDetailCode;
      detail[`DETAIL_WIRED_MSB:`DETAIL_WIRED_LSB] = wiredInDetailCode;
   end

endmodule // charger_status_decode

/* File: hw/charger_irq_status_regs.v */
// Charger interrupt mask, summary status, detail and flag registers with interrupt pin
`timescale 1ns/1ps
`include "charger_irq_map.vh"

module charger_irq_status_regs (
   input wire clk,
   input wire rstn,
   // Register port, fed by the serial interface engine
   input wire [7:0] regAddr,
   input wire regWriteEn,
   input wire [7:0] regWriteData,
   input wire regReadEn,
   output reg [7:0] regReadData,
   output reg regReadValid,
   // Sub-block conditions
   input wire [`BYPASS_CODE_W-1:0] bypassDetailCode,
   input wire [`CELL_CODE_W-1:0] cellDetailCode,
   input wire [`ENGINE_CODE_W-1:0] chargeEngineDetailCode,
   input wire thermalRegulationActive,
   input wire [`INPUT_CODE_W-1:0] wirelessInDetailCode,
   input wire [`INPUT_CODE_W-1:0] wiredInDetailCode,
   input wire cellAbsentFlag,
   input wire adaptiveInputCurrentLimit,
   // Interrupt indication and shared open-drain pin
   output reg chargerIrq,
   output wire irqPinOut,
   output wire irqPinOe,
   // Direct views for the surrounding logic
   output reg [7:0] chargerIrqFlags,
   output reg [7:0] chargerIrqMask
);

   wire [7:0] liveSummary;
   wire [7:0] liveDetail;
   reg [7:0] summaryStatus;
   reg [7:0] inputBatteryDetail;
   reg primed;
   wire [7:0] next_chargerIrqFlags;
   reg [7:0] next_chargerIrqMask;
   reg [7:0] next_regReadData;
   wire flagRead;
   wire maskWrite;
   wire [7:0] changed;
   wire [7:0] pendingUnmasked;

   charger_status_decode decoder (
      .bypassDetailCode(bypassDetailCode),
      .cellDetailCode(cellDetailCode),
      .chargeEngineDetailCode(chargeEngineDetailCode),
      .thermalRegulationActive(thermalRegulationActive),
      .wirelessInDetailCode(wirelessInDetailCode),
      .wiredInDetailCode(wiredInDetailCode),
      .cellAbsentFlag(cellAbsentFlag),
      .adaptiveInputCurrentLimit(adaptiveInputCurrentLimit),
      .summary(liveSummary),
      .detail(liveDetail)
   );

   assign flagRead = regReadEn && (regAddr == `ADDR_IRQ_FLAGS);
   assign maskWrite = regWriteEn && (regAddr == `ADDR_IRQ_MASK);

   // Status and detail copies are refreshed every cycle; the port never writes them
   always @(posedge clk) begin
      if (!rstn) begin
         summaryStatus <= `RESET_SUMMARY_STATUS;
         inputBatteryDetail <= `RESET_INPUT_BATTERY_DETAIL;
         primed <= 1'b0;
      end else begin
         summaryStatus <= liveSummary;
         inputBatteryDetail <= liveDetail;
         primed <= 1'b1;
      end
   end

   // First load after reset is a baseline, not a change, so no spurious flags at power-up
   assign changed = primed ? ((liveSummary ^ summaryStatus) & `SOURCE_BITS) : 8'h00;

   // Mask: software steers every source bit, reserved bit stays at its reset one
   always @* begin
      next_chargerIrqMask = chargerIrqMask;
      if (maskWrite) begin
         next_chargerIrqMask = (regWriteData & `SOURCE_BITS) |
                               (`RESET_IRQ_MASK & ~`SOURCE_BITS);
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         chargerIrqMask <= `RESET_IRQ_MASK;
      end else begin
         chargerIrqMask <= next_chargerIrqMask;
      end
   end

   // Per-bit flags: a change in the same cycle as the clearing read survives
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : flagBit
         assign next_chargerIrqFlags[i] = changed[i] |
                                          (chargerIrqFlags[i] & ~flagRead);
      end
   endgenerate

   // One register for the whole flag byte keeps a single driver per signal
   always @(posedge clk) begin
      if (!rstn) begin
         chargerIrqFlags <= `RESET_IRQ_FLAGS;
      end else begin
         chargerIrqFlags <= next_chargerIrqFlags;
      end
   end

   // Masking only gates chargerIrq and the pin; the flag itself is still kept
   assign pendingUnmasked = next_chargerIrqFlags & ~next_chargerIrqMask;

   always @(posedge clk) begin
      if (!rstn) begin
         chargerIrq <= 1'b0;
      end else begin
         chargerIrq <= |pendingUnmasked;
      end
   end

   // Open-drain pin pulls low while an unmasked flag is pending
   assign irqPinOut = 1'b0;
   assign irqPinOe = chargerIrq;

   // Read data: the flag value returned is the one before the clearing read
   always @* begin
      if (regAddr == `ADDR_IRQ_FLAGS) begin
         next_regReadData = chargerIrqFlags;
      end else if (regAddr == `ADDR_IRQ_MASK) begin
         next_regReadData = chargerIrqMask;
      end else if (regAddr == `ADDR_SUMMARY_STATUS) begin
         next_regReadData = summaryStatus;
      end else if (regAddr == `ADDR_INPUT_BATTERY_DETAIL) begin
         next_regReadData = inputBatteryDetail;
      end else begin
         next_regReadData = `READ_UNMAPPED;
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         regReadData <= `READ_UNMAPPED;
         regReadValid <= 1'b0;
      end else begin
         regReadValid <= regReadEn;
         if (regReadEn) begin
            regReadData <= next_regReadData;
         end
      end
   end

endmodule // charger_irq_status_regs

/* File: bench/charger_irq_status_regs_sva.sv */
// Port assertions for the charger interrupt and status block
`timescale 1ns/1ps
`include "charger_irq_map.vh"
module charger_irq_status_regs_sva (
   input wire clk,
   input wire rstn,
   input wire [7:0] regAddr,
   input wire regWriteEn,
   input wire [7:0] regWriteData,
   input wire regReadEn,
   input wire [7:0] regReadData,
   input wire regReadValid,
   input wire [`BYPASS_CODE_W-1:0] bypassDetailCode,
   input wire [`CELL_CODE_W-1:0] cellDetailCode,
   input wire [`ENGINE_CODE_W-1:0] chargeEngineDetailCode,
   input wire thermalRegulationActive,
   input wire [`INPUT_CODE_W-1:0] wirelessInDetailCode,
   input wire [`INPUT_CODE_W-1:0] wiredInDetailCode,
   input wire cellAbsentFlag,
   input wire adaptiveInputCurrentLimit,
   input wire chargerIrq,
   input wire irqPinOut,
   input wire irqPinOe,
   input wire [7:0] chargerIrqFlags,
   input wire [7:0] chargerIrqMask
);
   wire [17:0] live = {bypassDetailCode, cellDetailCode, chargeEngineDetailCode,
      thermalRegulationActive, wirelessInDetailCode, wiredInDetailCode, cellAbsentFlag,
      adaptiveInputCurrentLimit};
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence flagRead;
      regReadEn && regAddr == `ADDR_IRQ_FLAGS;
   endsequence
   // First edge after reset loads the baseline, so skip it
   sequence quiet;
      $stable(live) && $past(rstn);
   endsequence
   pin_follow_a: assert property (irqPinOe == chargerIrq && !irqPinOut)
      else $error("irq pin wrong");
   irq_gate_a: assert property (chargerIrq == |(chargerIrqFlags & ~chargerIrqMask))
      else $error("irq level wrong");
   read_answer_a: assert property (regReadEn |=> regReadValid)
      else $error("no read answer");
   mask_write_a: assert property (regWriteEn && regAddr == `ADDR_IRQ_MASK
      |=> chargerIrqMask == ($past(regWriteData) | 8'h02)) else $error("mask write");
   reserved_bit_a: assert property (chargerIrqMask[1] && !chargerIrqFlags[1])
      else $error("reserved bit");
   flag_read_a: assert property (flagRead |=> regReadData == $past(chargerIrqFlags))
      else $error("flag read data");
   flag_clear_a: assert property (flagRead ##0 quiet |=> chargerIrqFlags == 8'h00)
      else $error("flags not cleared");
   flag_hold_a: assert property (!regReadEn ##0 quiet |=> $stable(chargerIrqFlags))
      else $error("flag moved");
   wired_flag_a: assert property ($past(rstn) && $changed(wiredInDetailCode == 2'h3)
      |=> chargerIrqFlags[`BIT_WIRED_IN]) else $error("wired flag");
endmodule // charger_irq_status_regs_sva
bind charger_irq_status_regs charger_irq_status_regs_sva u_sva (.*);

/* File: bench/reg_host_model.sv */
// Host side of the byte register port
`timescale 1ns/1ps
module reg_host_model (
   input wire clk,
   output reg [7:0] regAddr = 8'h00,
   output reg regWriteEn = 1'b0,
   output reg [7:0] regWriteData = 8'h00,
   output reg regReadEn = 1'b0,
   input wire [7:0] regReadData,
   input wire regReadValid
);
   task wr(input [7:0] a, input [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWriteData <= d;
      regWriteEn <= 1'b1;
      @(posedge clk);
      regWriteEn <= 1'b0;
      // Released lines carry junk, never the old value
      regAddr <= ~a;
      regWriteData <= ~d;
   endtask
   task rd(input [7:0] a, output [7:0] d, output ok);
      @(posedge clk);
      regAddr <= a;
      regReadEn <= 1'b1;
      @(posedge clk);
      regReadEn <= 1'b0;
      regAddr <= ~a;
      // Answer stands for one cycle after the taking edge
      @(posedge clk);
      ok = regReadValid;
      d = regReadData;
   endtask
endmodule // reg_host_model

/* File: bench/testbench.sv */
// Self-checking testbench for the charger interrupt and status block
`timescale 1ns/1ps
`include "charger_irq_map.vh"
module testbench;
   reg clk = 1'b0;
   reg rstn = 1'b0;
   reg [3:0] bypassDetailCode = 4'h0;
   reg [2:0] cellDetailCode = 3'h0;
   reg [3:0] chargeEngineDetailCode = 4'h0;
   reg thermalRegulationActive = 1'b0;
   reg [1:0] wirelessInDetailCode = 2'h0;
   reg [1:0] wiredInDetailCode = 2'h0;
   reg cellAbsentFlag = 1'b0;
   reg adaptiveInputCurrentLimit = 1'b0;
   wire [7:0] regAddr, regWriteData, regReadData, chargerIrqFlags, chargerIrqMask;
   wire regWriteEn, regReadEn, regReadValid, chargerIrq, irqPinOut, irqPinOe;
   integer err_count = 0;
   integer cmp_count = 0;
   integer i;
   reg [7:0] got;
   reg ok;
   charger_irq_status_regs u_dut (.*);
   reg_host_model u_host (.*);
   initial forever #5 clk = ~clk;
   task chk(input [7:0] g, input [7:0] e);
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         err_count = err_count + 1;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task rdchk(input [7:0] a, input [7:0] e);
      u_host.rd(a, got, ok);
      chk({7'h00, ok}, 8'h01);
      chk(got, e);
   endtask
   function automatic [7:0] expSum();
      expSum = {!adaptiveInputCurrentLimit, wiredInDetailCode == 2'h3,
         wirelessInDetailCode == 2'h3, !thermalRegulationActive && (chargeEngineDetailCode < 4'h4
         || chargeEngineDetailCode == 4'h5 || chargeEngineDetailCode == 4'h8),
         cellDetailCode == 3'h3 || cellDetailCode == 3'h4, !cellAbsentFlag, 1'b0,
         bypassDetailCode == 4'h0};
   endfunction
   function automatic [7:0] expDet();
      expDet = {1'b0, wiredInDetailCode, wirelessInDetailCode, 2'b00, cellAbsentFlag};
   endfunction
   task t_reset;
      rdchk(`ADDR_IRQ_MASK, 8'hFF);
      rdchk(8'hC0, 8'h00);
      u_host.wr(`ADDR_SUMMARY_STATUS, 8'h02);
      u_host.wr(`ADDR_INPUT_BATTERY_DETAIL, 8'hFF);
      rdchk(`ADDR_SUMMARY_STATUS, expSum());
      rdchk(`ADDR_INPUT_BATTERY_DETAIL, expDet());
      u_host.wr(`ADDR_IRQ_MASK, 8'h00);
      rdchk(`ADDR_IRQ_MASK, 8'h02);
      $display("test reset done");
   endtask
   task t_decode;
      // Walks every engine code with and without thermal regulation
      for (i = 0; i < 32; i = i + 1) begin
         @(posedge clk);
         bypassDetailCode <= i[3:0];
         cellDetailCode <= i[2:0];
         chargeEngineDetailCode <= i[3:0];
         thermalRegulationActive <= i[4];
         wirelessInDetailCode <= i[1:0];
         wiredInDetailCode <= i[3:2];
         cellAbsentFlag <= i[0];
         adaptiveInputCurrentLimit <= i[1];
         // New levels must land before the expectation is formed
         @(posedge clk);
         rdchk(`ADDR_SUMMARY_STATUS, expSum());
         rdchk(`ADDR_INPUT_BATTERY_DETAIL, expDet());
      end
      $display("test decode done");
   endtask
   task t_flags;
      u_host.wr(`ADDR_IRQ_MASK, 8'hFF);
      wiredInDetailCode <= 2'h0;
      @(posedge clk);
      u_host.rd(`ADDR_IRQ_FLAGS, got, ok);
      rdchk(`ADDR_IRQ_FLAGS, 8'h00);
      wiredInDetailCode <= 2'h3;
      @(posedge clk);
      #1;
      chk({chargerIrqFlags[7:1], chargerIrq}, 8'h40);
      rdchk(`ADDR_IRQ_FLAGS, 8'h40);
      rdchk(`ADDR_IRQ_FLAGS, 8'h00);
      u_host.wr(`ADDR_IRQ_MASK, 8'hBF);
      wiredInDetailCode <= 2'h1;
      @(posedge clk);
      #1;
      chk({6'h00, chargerIrq, irqPinOe}, 8'h03);
      rdchk(`ADDR_IRQ_FLAGS, 8'h40);
      chk({6'h00, chargerIrq, irqPinOe}, 8'h00);
      $display("test flags done");
   endtask
   task print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_reset;
      t_decode;
      t_flags;
      print_verdict;
   end
   initial begin
      #20000;
      err_count = err_count + 1;
      print_verdict;
   end
endmodule // testbench
